// ===== rtl/led_matrix_defs.vh
/*
 constants for the indicator led latch matrix: register offsets, field
 positions, reset values and timing counts. assumes a 25 MHz pclk.
*/
//
// Behaviour
// R1 - fourteen leds, green or red, any source
// R2 - normal mode: led follows mapped signal
// R3 - about 10 ms on and off delay; code waits one cycle up to one 10 ms refresh period
// R4 - latched mode holds led until release
// R5 - blink option flashes led while active
// R6 - stored latches come back after restart
// R7 - store acts only together with latch
// R8 - modes: normal, latched, blink-latched
// R9 - logic reaches leds only through matrix
// R10 - twenty logic outputs are selectable sources
// R11 - 64 network inputs, 16 network errors selectable
// R12 - five comm port activity sources
// R13 - release-all clears every latched led
// R14 - panel release needs password, outside
// R15 - function key release pulse one second
// R16 - release acts only if something latched
// R17 - active mapped signal inhibits object control
// R18 - event pulses never inhibit objects
// R19 - blocking entries follow enabled stages, outside
// R20 - release also frees latched digital outputs
// R21 - one shared blink phase for all
`ifndef LED_MATRIX_DEFS_VH
`define LED_MATRIX_DEFS_VH

// register byte offsets
`define LED_CFG_BASE   8'h00
`define RELEASE_OFS    8'h40
`define LATCH_STAT_OFS 8'h44
`define LED_STAT_OFS   8'h48
`define OBJ_CFG_BASE   8'h60
`define INHIBIT_OFS    8'h80

// led config fields
`define LED_SRC_R      7:0
`define LED_RED_B      8
`define LED_MODE_R     10:9
`define LED_STORE_B    11
`define LED_CFG_RST    12'h000

// connection modes
`define MODE_NORMAL    2'b00
`define MODE_LATCHED   2'b01
`define MODE_BLINK     2'b10

// object block config fields
`define OBJ_SRC_R      7:0
`define OBJ_EN_B       8
`define OBJ_CFG_RST    9'h000

// source vector layout
`define SRC_GEN_LO     0
`define SRC_LOGIC_LO   32
`define SRC_NET_LO     52
`define SRC_ERR_LO     116
`define SRC_COMM_LO    132
`define SRC_EVT_LO     137
`define SRC_COUNT      153

// timing
`define CLK_HZ         25000000
`define LED_DELAY_MS   10
`define BLINK_HALF_MS  250
`define REFRESH_CYCLES (`LED_DELAY_MS * (`CLK_HZ / 1000))
`define BLINK_TICKS    (`BLINK_HALF_MS / `LED_DELAY_MS)

`endif

// ===== rtl/indicator_led_latch_matrix.v
/*
 front-panel indicator matrix with latch, blink and store options, a common
 latch release and the object block matrix, behind an apb slave.
 assumes all source signals come from logic on pclk; nonvolatile storage of
 latch states lives outside and hands back its copy at restart.
*/
`timescale 1ns/1ps
`default_nettype none
`include "led_matrix_defs.vh"

module indicator_led_latch_matrix #(
    parameter N_LED          = 14,
    parameter N_OBJ          = 8,
    parameter REFRESH_CYCLES = `REFRESH_CYCLES,
    parameter BLINK_TICKS    = `BLINK_TICKS
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [7:0]   paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output reg          pready,
    output reg          pslverr,
    input  wire [31:0]  stage_sig,
    input  wire [19:0]  logic_out,
    input  wire [63:0]  network_input_bits,
    input  wire [15:0]  network_error_bits,
    input  wire [4:0]   comm_port_activity,
    input  wire [15:0]  obj_cmd_pulse,
    input  wire         panel_release,
    input  wire         function_key_release,
    input  wire [13:0]  restore_latch,
    output reg  [13:0]  led_green,
    output reg  [13:0]  led_red,
    output reg  [7:0]   obj_inhibit,
    output reg          latched_output_release,
    output reg  [13:0]  stored_latch_state
);

    localparam SRC_N = `SRC_COUNT;

    ////////////////////////////////////////////////////////////////////////
    // source matrix

    // logic results enter only here, never straight onto a led R9
    wire [SRC_N-1:0] src_vec = {obj_cmd_pulse,
                                comm_port_activity,
                                network_error_bits,
                                network_input_bits,
                                logic_out,
                                stage_sig}; // R10 R11 R12

    // out-of-range selections read as inactive rather than unknown
    function pick;
        input [SRC_N-1:0] v;
        input [7:0]       idx;
        begin
            pick = (idx < SRC_N) ? v[idx] : 1'b0;
        end
    endfunction

    function is_event;
        input [7:0] idx;
        begin
            is_event = (idx >= `SRC_EVT_LO);
        end
    endfunction

    // latched and blink-latched both hold their state; code 3 acts as normal
    function latching;
        input [1:0] m;
        begin
            latching = (m == `MODE_LATCHED) || (m == `MODE_BLINK);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration and state

    reg [11:0] led_cfg_reg [0:N_LED-1];
    reg [8:0]  obj_cfg_reg [0:N_OBJ-1];
    reg [13:0] latch_reg;
    reg        restored_reg;
    reg [31:0] refresh_cnt_reg;
    reg        tick_reg;
    reg [7:0]  blink_cnt_reg;
    reg        blink_phase_reg;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    wire       setup_acc = psel & penable & ~pready;
    wire       done_acc  = psel & penable & pready;
    wire       led_hit   = (paddr < 8'h38) && (paddr[1:0] == 2'b00);
    wire       obj_hit   = (paddr[7:5] == 3'b011) && (paddr[1:0] == 2'b00);
    wire [3:0] led_idx   = paddr[5:2];
    wire [2:0] obj_idx   = paddr[4:2];

    // unmapped offsets answer with pslverr and leave every register alone
    reg        hit;
    reg [31:0] rd_data;
    integer    k;

    always @* begin
        hit = 1'b1;
        rd_data = 32'h0000_0000;
        if (led_hit) begin
            rd_data[11:0] = led_cfg_reg[led_idx];
        end else if (obj_hit) begin
            rd_data[8:0] = obj_cfg_reg[obj_idx];
        end else begin
            case (paddr)
                // the release register reads 0; the request is the write itself
                `RELEASE_OFS:    rd_data = 32'h0000_0000;
                `LATCH_STAT_OFS: rd_data[13:0] = latch_reg;
                `LED_STAT_OFS:   rd_data = {2'b00, led_red, 2'b00, led_green};
                `INHIBIT_OFS:    rd_data[7:0] = obj_inhibit;
                default:         hit = 1'b0;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_acc;
            pslverr <= setup_acc & ~hit;
            prdata  <= (setup_acc & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // writes land at the edge that completes the transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (k = 0; k < N_LED; k = k + 1)
                led_cfg_reg[k] <= `LED_CFG_RST;
            for (k = 0; k < N_OBJ; k = k + 1)
                obj_cfg_reg[k] <= `OBJ_CFG_RST;
        end else if (done_acc & pwrite) begin
            if (led_hit)
                led_cfg_reg[led_idx] <= pwdata[11:0];
            if (obj_hit)
                obj_cfg_reg[obj_idx] <= pwdata[8:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refresh tick and shared blink divider

    // a shared 10 ms refresh instead of per-led timers keeps area small;
    // the delay lands between one cycle and one refresh period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh_cnt_reg <= 32'h0000_0000;
            tick_reg        <= 1'b0;
            blink_cnt_reg   <= 8'h00;
            blink_phase_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (refresh_cnt_reg == REFRESH_CYCLES - 1) begin
                refresh_cnt_reg <= 32'h0000_0000;
                tick_reg        <= 1'b1; // R3
            end else begin
                refresh_cnt_reg <= refresh_cnt_reg + 32'h0000_0001;
            end
            if (tick_reg) begin
                if (blink_cnt_reg == BLINK_TICKS - 1) begin
                    blink_cnt_reg   <= 8'h00;
                    blink_phase_reg <= ~blink_phase_reg; // R21
                end else begin
                    blink_cnt_reg <= blink_cnt_reg + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led behaviour

    reg  [13:0] sig_vec;
    reg  [13:0] lit_vec;
    reg  [13:0] latch_set;
    reg  [13:0] red_vec;
    reg  [13:0] store_eff;
    reg  [13:0] latch_mask;
    reg  [13:0] led_green_next;
    reg  [13:0] led_red_next;
    reg  [1:0]  mode;
    integer     i;

    // blinking leds read the one shared phase, so they all toggle together

    always @* begin
        sig_vec   = 14'h0000;
        lit_vec   = 14'h0000;
        latch_set = 14'h0000;
        red_vec   = 14'h0000;
        store_eff = 14'h0000;
        latch_mask = 14'h0000;
        mode      = `MODE_NORMAL;
        for (i = 0; i < N_LED; i = i + 1) begin
            mode       = led_cfg_reg[i][`LED_MODE_R];
            sig_vec[i] = pick(src_vec, led_cfg_reg[i][`LED_SRC_R]); // R1
            red_vec[i] = led_cfg_reg[i][`LED_RED_B]; // R1
            latch_mask[i] = latching(mode); // R8
            store_eff[i]  = led_cfg_reg[i][`LED_STORE_B] & latch_mask[i]; // R7
            case (mode) // R8
                `MODE_LATCHED: begin
                    latch_set[i] = sig_vec[i];
                    lit_vec[i]   = sig_vec[i] | latch_reg[i]; // R4
                end
                `MODE_BLINK: begin
                    latch_set[i] = sig_vec[i];
                    lit_vec[i]   = (sig_vec[i] | latch_reg[i]) &
                                   blink_phase_reg; // R5
                end
                default: begin
                    lit_vec[i] = sig_vec[i]; // R2
                end
            endcase
        end
        led_green_next = lit_vec & ~red_vec; // R1
        led_red_next   = lit_vec & red_vec;
    end

    // panel password and key pulse length are checked before these arrive
    wire sw_release = done_acc & pwrite & (paddr == `RELEASE_OFS) & pwdata[0];
    wire hw_release = panel_release | function_key_release; // R14 R15
    wire rel_req    = sw_release | hw_release; // R13
    // restored bits under a normal-mode led are not a live latch
    wire rel_now    = rel_req & (|(latch_reg & latch_mask)); // R16
    reg  [13:0] latch_next;

    // a set in the release cycle survives the release
    always @* begin
        if (!restored_reg) begin
            latch_next = restore_latch; // R6
        end else begin
            latch_next = (rel_now ? 14'h0000 : latch_reg) |
                         (tick_reg ? latch_set : 14'h0000); // R4 R13
        end
    end

    // stored state trails the latch by one cycle; the outside store samples it

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg              <= 14'h0000;
            restored_reg           <= 1'b0;
            led_green              <= 14'h0000;
            led_red                <= 14'h0000;
            latched_output_release <= 1'b0;
            stored_latch_state     <= 14'h0000;
        end else begin
            restored_reg           <= 1'b1;
            latch_reg              <= latch_next;
            latched_output_release <= rel_now; // R20
            stored_latch_state     <= latch_reg & store_eff; // R6 R7
            if (tick_reg) begin
                led_green <= led_green_next; // R3
                led_red   <= led_red_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // object block matrix

    integer     j;
    reg  [7:0]  obj_inhibit_next;

    // event sources are masked so a short command pulse never locks an object
    always @* begin
        obj_inhibit_next = 8'h00;
        for (j = 0; j < N_OBJ; j = j + 1) begin
            obj_inhibit_next[j] = obj_cfg_reg[j][`OBJ_EN_B] &
                                  pick(src_vec, obj_cfg_reg[j][`OBJ_SRC_R]) &
                                  ~is_event(obj_cfg_reg[j][`OBJ_SRC_R]); // R17 R18
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            obj_inhibit <= 8'h00;
        end else begin
            obj_inhibit <= obj_inhibit_next;
        end
    end

endmodule

`default_nettype wire

// ===== tb/led_matrix_properties.sv
/* port checks for the indicator led matrix.
 assumes REFRESH_CYCLES of at least 8 and the register map of the defs header. */
`timescale 1ns/1ps
`default_nettype none
`include "led_matrix_defs.vh"
module led_matrix_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] stage_sig,
    input wire logic [19:0] logic_out,
    input wire logic [63:0] network_input_bits,
    input wire logic [15:0] network_error_bits,
    input wire logic [4:0]  comm_port_activity,
    input wire logic        panel_release,
    input wire logic        function_key_release,
    input wire logic [13:0] led_green,
    input wire logic [13:0] led_red,
    input wire logic [7:0]  obj_inhibit,
    input wire logic        latched_output_release
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// release request seen at the previous edge, so the pulse can point back at it
logic rel_req_q;
always @(posedge pclk)
    rel_req_q <= panel_release || function_key_release || (psel && penable && pready
        && pwrite && paddr == `RELEASE_OFS && pwdata[0]);
////////////////////////////////////////////////////////////////////////////////
a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
a_no_ready_idle: assert property (!(psel && penable) |=> !pready)
    else $error("answer without access");
a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
a_err_unmapped: assert property (pready && psel && paddr == 8'h38 |-> pslverr)
    else $error("unmapped address without error");
a_release_cause: assert property (latched_output_release |-> rel_req_q)
    else $error("release pulse without request");
// leds move only on the shared refresh tick, so never twice within 7 cycles
a_led_hold: assert property ($changed({led_green, led_red})
    |=> $stable({led_green, led_red})[*6])
    else $error("leds changed between ticks");
a_inhibit_event: assert property (!psel && !$past(psel) && $stable({stage_sig, logic_out,
    network_input_bits, network_error_bits, comm_port_activity})
    |=> $stable(obj_inhibit))
    else $error("inhibit moved by event source");
c_release: cover property (latched_output_release);
c_error: cover property (pready && pslverr);
c_inhibit: cover property ($rose(obj_inhibit[0]));
endmodule
bind indicator_led_latch_matrix led_matrix_checker i_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stage_sig,
    .logic_out, .network_input_bits, .network_error_bits, .comm_port_activity,
    .panel_release, .function_key_release, .led_green, .led_red, .obj_inhibit,
    .latched_output_release);
`default_nettype wire

// ===== tb/source_model.sv
/* far side: internal control sources, one index active at a time, and a
 function key release pulse. assumes pclk of the matrix. */
`timescale 1ns/1ps
`default_nettype none
module source_model #(parameter KEY_PULSE = 4) (
    input  wire logic        pclk,
    input  wire logic [7:0]  src_idx,
    input  wire logic        src_on,
    input  wire logic        key_press,
    output logic      [31:0] stage_sig,
    output logic      [19:0] logic_out,
    output logic      [63:0] network_input_bits,
    output logic      [15:0] network_error_bits,
    output logic      [4:0]  comm_port_activity,
    output logic      [15:0] obj_cmd_pulse,
    output logic             function_key_release
);
int key_cnt = 0;
assign {obj_cmd_pulse, comm_port_activity, network_error_bits, network_input_bits,
    logic_out, stage_sig} = src_on ? (153'd1 << src_idx) : 153'd0;
// pulse span shortened from one second to keep the run short
always @(posedge pclk) begin
    if (key_press)
        key_cnt <= KEY_PULSE;
    else if (key_cnt > 0)
        key_cnt <= key_cnt - 1;
end
assign function_key_release = (key_cnt > 0);
endmodule
`default_nettype wire

// ===== tb/test_indicator_led_latch_matrix.sv
/* self-checking bench: apb tasks and source model drive the led matrix.
 assumes nothing of the apb answer time; the watchdog ends a hang. */
`timescale 1ns/1ps
`default_nettype none
module test_indicator_led_latch_matrix;
logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
logic        panel_release, function_key_release, latched_output_release;
logic        key_press, src_on;
logic [7:0]  paddr, src_idx, obj_inhibit, ones;
logic [31:0] pwdata, prdata, q, stage_sig;
logic [19:0] logic_out;
logic [63:0] network_input_bits;
logic [15:0] network_error_bits, obj_cmd_pulse;
logic [4:0]  comm_port_activity;
logic [13:0] restore_latch, led_green, led_red, stored_latch_state;
int          failures = 0, n_compared = 0, rel_cnt = 0;
indicator_led_latch_matrix #(.REFRESH_CYCLES(8), .BLINK_TICKS(2)) i_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stage_sig,
    .logic_out, .network_input_bits, .network_error_bits, .comm_port_activity,
    .obj_cmd_pulse, .panel_release, .function_key_release, .restore_latch, .led_green,
    .led_red, .obj_inhibit, .latched_output_release, .stored_latch_state);
source_model i_src (.pclk, .src_idx, .src_on, .key_press, .stage_sig, .logic_out,
    .network_input_bits, .network_error_bits, .comm_port_activity, .obj_cmd_pulse,
    .function_key_release);
////////////////////////////////////////////////////////////////////////////////
initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
end
always @(posedge pclk) if (latched_output_release === 1'b1) rel_cnt <= rel_cnt + 1;
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
        failures++;
        $display("BAD %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic drv(input logic [7:0] i, input logic v);
    src_idx <= i; src_on <= v;
endtask
task automatic wt(input int n);
    repeat (n) @(posedge pclk);
endtask
task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    panel_release = 0; restore_latch = 0; src_idx = 0; src_on = 0; key_press = 0;
    wt(8);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h00, 0); chk("cfg0", q, 32'h0);
    apb(0, 8'h38, 0); chk("unmapped", {31'h0, e}, 32'h1);
    apb(1, 8'h00, 32'h23); drv(35, 1); wt(10); // 35 = logic output 3
    chk("normal on", {led_red[0], led_green[0]}, 2'b01);
    apb(0, 8'h48, 0); chk("led stat", q, 32'h1);
    drv(35, 0); wt(10); chk("normal off", led_green[0], 1'b0);
    apb(1, 8'h04, 32'h339); drv(57, 1); wt(10); drv(57, 0); wt(10);
    chk("latched red", led_red[1], 1'b1);
    apb(0, 8'h44, 0); chk("latch stat", q, 32'h2);
    apb(1, 8'h40, 1); wt(2); chk("release pulse", rel_cnt, 1);
    apb(0, 8'h44, 0); chk("latch clear", q, 32'h0);
    wt(10); chk("latched off", led_red[1], 1'b0);
    apb(1, 8'h40, 1); wt(2); chk("idle release", rel_cnt, 1);
    apb(1, 8'h08, 32'h485); drv(133, 1); wt(10); drv(133, 0); ones = 0;
    repeat (64) begin @(posedge pclk); ones += led_green[2]; end
    chk("blink duty", ones, 32);
    panel_release <= 1'b1; @(posedge pclk); panel_release <= 1'b0;
    wt(2); chk("panel release", rel_cnt, 2);
    apb(1, 8'h0c, 32'ha78); apb(1, 8'h10, 32'h878);
    drv(120, 1); wt(10); drv(120, 0); wt(2);
    chk("store", stored_latch_state, 14'h0008);
    key_press <= 1'b1; @(posedge pclk); key_press <= 1'b0; wt(8);
    chk("key release", rel_cnt, 3);
    chk("store clear", stored_latch_state, 14'h0);
    restore_latch <= 14'h0120; presetn <= 1'b0; wt(2); presetn <= 1'b1; wt(2);
    apb(0, 8'h44, 0); chk("restore", q, 32'h120);
    apb(1, 8'h60, 32'h102); apb(1, 8'h64, 32'h189);
    drv(2, 1); wt(3); chk("inhibit", obj_inhibit, 8'h01);
    apb(0, 8'h80, 0); chk("inhibit stat", q, 32'h1);
    drv(137, 1); wt(3); chk("event no inhibit", obj_inhibit, 8'h00);
    summarize();
end
endmodule
`default_nettype wire
